/* atcc_pkg.sv */
// atcc_pkg: register map, field positions, reset values and timing counts for the converter control
// assumes: 32-bit apb, one register per aligned word, byte-wide data in the low bits
package atcc_pkg;

  // ----------------------------------------------------------------
  // register byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL0 = 8'h00;  // start, busy, enable, alignment, channel
  localparam logic [7:0] ADDR_CTRL1 = 8'h04;  // input source, prescaler
  localparam logic [7:0] ADDR_REFGAIN = 8'h08;
  localparam logic [7:0] ADDR_TRIGCMP = 8'h0c;
  localparam logic [7:0] ADDR_DELAY = 8'h10;
  localparam logic [7:0] ADDR_BANDGAP = 8'h14;
  localparam logic [7:0] ADDR_LOWH = 8'h18;
  localparam logic [7:0] ADDR_LOWL = 8'h1c;
  localparam logic [7:0] ADDR_HIGHH = 8'h20;
  localparam logic [7:0] ADDR_HIGHL = 8'h24;
  localparam logic [7:0] ADDR_RESH = 8'h28;
  localparam logic [7:0] ADDR_RESL = 8'h2c;
  localparam logic [7:0] ADDR_STATUS = 8'h30;  // bit0 compare event, bit1 end of conversion; write 1 clears

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CTRL0_START = 7;
  localparam int CTRL0_BUSY = 6;
  localparam int CTRL0_EN = 5;
  localparam int CTRL0_ALIGN = 4;
  localparam int TRIG_SEL = 7;
  localparam int TRIG_DLY = 6;
  localparam int TRIG_PWM_EVENT_SOURCE_SELECT = 5;
  localparam int ST_CMP = 0;
  localparam int ST_EOC = 1;

  // ----------------------------------------------------------------
  // write masks (unimplemented bits read zero) and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] MASK_CTRL0 = 8'hbf;
  localparam logic [7:0] MASK_CTRL1 = 8'he7;
  localparam logic [7:0] MASK_REFGAIN = 8'h9f;
  localparam logic [7:0] MASK_TRIGCMP = 8'hfb;
  localparam logic [7:0] MASK_BANDGAP = 8'h01;
  localparam logic [7:0] RST_BYTE = 8'h00;

  // ----------------------------------------------------------------
  // input source codes and conversion timing
  // ----------------------------------------------------------------
  localparam logic [2:0] SRC_EXT = 3'h0;
  localparam logic [2:0] SRC_OPAMP = 3'h1;
  localparam logic [2:0] SRC_VREF_AMP = 3'h4;
  localparam logic [2:0] SRC_VREF_HALF = 3'h5;
  localparam logic [4:0] SAMPLE_CLKS = 5'h04;
  localparam logic [4:0] CONV_CLKS = 5'h0c;
  localparam logic [4:0] TOTAL_CLKS = 5'h10;

  typedef enum logic [2:0] {
    ATCC_IDLE = 3'b001,
    ATCC_SAMPLE = 3'b010,
    ATCC_CONVERT = 3'b100
  } atcc_state_t;

endpackage : atcc_pkg

/* atcc_prescaler.sv */
// atcc_prescaler: converter clock enable, system clock divided by 2**code
// assumes: one system clock; the pulse is a clock enable, not a clock
module atcc_prescaler
  import atcc_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // control
  input wire logic run,
  input wire logic [2:0] code,
  // converter clock enable
  output logic tick
);

  logic [6:0] cnt_ff;
  logic [6:0] nxt_cnt;
  logic [6:0] lastCount;

  // divisor minus one for the chosen power of two
  assign lastCount = 7'((8'h01 << code) - 8'h01);
  assign tick = run && (cnt_ff == lastCount);
  assign nxt_cnt = (!run || tick) ? 7'h00 : 7'(cnt_ff + 7'h01);

  // free counter, held at zero while idle so every conversion starts aligned
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      cnt_ff <= 7'h00;
    else
      cnt_ff <= nxt_cnt;
  end

endmodule : atcc_prescaler

/* atcc_ctrl.sv */
// atcc_ctrl: digital control of a 12-bit successive-approximation converter
// assumes: apb master on clk_sys; pwm flags come from logic on the same clock; the analog
// core takes the routing outputs and delivers its result with a valid pulse
// ----------------------------------------------------------------
// top module
// ----------------------------------------------------------------
// What this block does
// - source codes 100, 101 route amplified reference, half of it; 110/111 ground
// - any internal source disconnects the external channel
// - converter clock is system clock divided by 1 to 128, powers of two
// - amplifier enable bit powers the reference amplifier only while set
// - amplifier input picks reference pin at 0, bandgap at 1 disconnecting pin
// - reference select picks supply, reference pin, or amplifier; pin off otherwise
// - two-bit gain field sets amplifier gain 1, 1.667, 2.5, 3.333
// - trigger select chooses start bit at 0, pwm event path at 1
// - start bit written high then low begins a conversion
// - pwm source bit picks period match at 0, duty match at 1
// - duty channel field picks channel 0, 1, 2; code 11 also channel 2
// - delayed start counts system clocks from the flag rising edge to delay value
// - compare condition picks one of four bound tests, only for source 001
// - bound registers follow result alignment, left or right justified
// - bound registers keep contents while the converter is disabled
// - busy flag rises when a conversion starts and falls when it ends
// - completion sets the interrupt request flag and raises interrupt if enabled
// - bandgap enable turns bandgap on; at zero the output is held low
// - each conversion takes 4 sampling and 12 converting converter clocks
// - converter enable powers the converter; clearing keeps result and bounds
module atcc_ctrl
  import atcc_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // pwm event flags
  input wire logic pwmPeriodFlag,
  input wire logic [2:0] pwmDutyFlag,
  // analog core
  input wire logic [11:0] conversionResult,
  input wire logic resultValid,
  output logic converterEnable,
  output logic convClockTick,
  output logic sampling,
  output logic [2:0] inputSourceSelect,
  output logic [3:0] externalChannelSelect,
  output logic externalChannelConnect,
  output logic gainAmpEnable,
  output logic ampRefInputPinConnect,
  output logic bandgapToAmp,
  output logic bandgapEnable,
  output logic [1:0] referenceSelect,
  output logic externalRefPinConnect,
  output logic [1:0] gainSelect,
  // events toward the processor
  output logic convInterruptFlag,
  output logic convInterrupt,
  output logic compareInterrupt,
  // interrupt enables
  input wire logic convIntEnable,
  input wire logic cmpIntEnable
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0] ctrl0_ff;
  logic [7:0] ctrl1_ff;
  logic [7:0] refGain_ff;
  logic [7:0] trigCmp_ff;
  logic [7:0] delay_ff;
  logic [7:0] bandgap_ff;
  logic [7:0] lowH_ff;
  logic [7:0] lowL_ff;
  logic [7:0] highH_ff;
  logic [7:0] highL_ff;
  logic [11:0] result_ff;
  logic [1:0] status_ff;
  logic busy_ff;
  logic pwmSel_ff;
  logic dlyRun_ff;
  logic [7:0] dlyCnt_ff;
  logic [4:0] clkCnt_ff;
  atcc_state_t state_ff;
  atcc_state_t nxt_state;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  logic wrEn;
  logic [7:0] wByte;
  logic hitAny;
  logic convEnabled;
  logic alignRight;

  assign pready = 1'b1;
  assign wrEn = psel && penable && pwrite;
  assign wByte = pwdata[7:0];
  assign convEnabled = ctrl0_ff[CTRL0_EN];
  assign alignRight = ctrl0_ff[CTRL0_ALIGN];
  assign hitAny = (paddr <= ADDR_STATUS) && (paddr[1:0] == 2'h0);
  assign pslverr = psel && penable && !hitAny;

  // ----------------------------------------------------------------
  // justification of 12-bit values into byte pairs
  // ----------------------------------------------------------------
  function automatic logic [7:0] hiByte(input logic [11:0] v, input logic right);
    hiByte = right ? {4'h0, v[11:8]} : v[11:4];
  endfunction : hiByte

  function automatic logic [7:0] loByte(input logic [11:0] v, input logic right);
    loByte = right ? v[7:0] : {v[3:0], 4'h0};
  endfunction : loByte

  function automatic logic [11:0] join12(input logic [7:0] h, input logic [7:0] l, input logic right);
    join12 = right ? {h[3:0], l} : {h, l[7:4]};
  endfunction : join12

  // ----------------------------------------------------------------
  // control register writes
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      ctrl0_ff <= RST_BYTE;
      ctrl1_ff <= RST_BYTE;
      refGain_ff <= RST_BYTE;
      trigCmp_ff <= RST_BYTE;
      delay_ff <= RST_BYTE;
      bandgap_ff <= RST_BYTE;
    end
    else if (wrEn)
    begin
      if (paddr == ADDR_CTRL0) ctrl0_ff <= wByte & MASK_CTRL0;
      if (paddr == ADDR_CTRL1) ctrl1_ff <= wByte & MASK_CTRL1;
      if (paddr == ADDR_REFGAIN) refGain_ff <= wByte & MASK_REFGAIN;
      if (paddr == ADDR_TRIGCMP) trigCmp_ff <= wByte & MASK_TRIGCMP;
      if (paddr == ADDR_DELAY) delay_ff <= wByte;
      if (paddr == ADDR_BANDGAP) bandgap_ff <= wByte & MASK_BANDGAP;
    end
  end

  // bounds are written only while the converter is enabled
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      lowH_ff <= RST_BYTE;
      lowL_ff <= RST_BYTE;
      highH_ff <= RST_BYTE;
      highL_ff <= RST_BYTE;
    end
    else if (wrEn && convEnabled)
    begin
      if (paddr == ADDR_LOWH) lowH_ff <= wByte;
      if (paddr == ADDR_LOWL) lowL_ff <= wByte;
      if (paddr == ADDR_HIGHH) highH_ff <= wByte;
      if (paddr == ADDR_HIGHL) highL_ff <= wByte;
    end
  end

  // ----------------------------------------------------------------
  // analog routing
  // ----------------------------------------------------------------
  assign converterEnable = convEnabled;
  assign inputSourceSelect = ctrl1_ff[7:5];
  assign externalChannelSelect = ctrl0_ff[3:0];
  assign externalChannelConnect = convEnabled && (ctrl1_ff[7:5] == SRC_EXT);
  assign gainAmpEnable = refGain_ff[7];
  assign bandgapToAmp = refGain_ff[4];
  assign ampRefInputPinConnect = !refGain_ff[4];
  assign referenceSelect = refGain_ff[3:2];
  assign externalRefPinConnect = (refGain_ff[3:2] == 2'h1);
  assign gainSelect = refGain_ff[1:0];
  assign bandgapEnable = bandgap_ff[0];

  // ----------------------------------------------------------------
  // trigger selection
  // ----------------------------------------------------------------
  logic swTrig;
  logic dutyFlag;
  logic pwmFlag;
  logic pwmRise;
  logic dlyDone;
  logic pwmTrig;
  logic startConv;
  logic idle;
  logic startBitFall;

  assign idle = (state_ff == ATCC_IDLE);
  // a start bit held high, then written low, fires once
  assign startBitFall = wrEn && (paddr == ADDR_CTRL0) && ctrl0_ff[CTRL0_START] && !wByte[CTRL0_START];
  assign swTrig = !trigCmp_ff[TRIG_SEL] && startBitFall;
  assign dutyFlag = (trigCmp_ff[1:0] == 2'h0) ? pwmDutyFlag[0] :
                    (trigCmp_ff[1:0] == 2'h1) ? pwmDutyFlag[1] : pwmDutyFlag[2];
  assign pwmFlag = trigCmp_ff[TRIG_PWM_EVENT_SOURCE_SELECT] ? dutyFlag : pwmPeriodFlag;
  assign pwmRise = pwmFlag && !pwmSel_ff;
  assign dlyDone = dlyRun_ff && (dlyCnt_ff >= delay_ff);
  assign pwmTrig = trigCmp_ff[TRIG_SEL] &&
                   (trigCmp_ff[TRIG_DLY] ? dlyDone : pwmRise);
  assign startConv = idle && convEnabled && (swTrig || pwmTrig);

  // edge detect of the selected flag and the delay counter
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      pwmSel_ff <= 1'b0;
      dlyRun_ff <= 1'b0;
      dlyCnt_ff <= 8'h00;
    end
    else
    begin
      pwmSel_ff <= pwmFlag;
      if (pwmRise && trigCmp_ff[TRIG_DLY] && !dlyRun_ff)
      begin
        dlyRun_ff <= 1'b1;
        dlyCnt_ff <= 8'h01;
      end
      else if (dlyDone || !trigCmp_ff[TRIG_DLY])
        dlyRun_ff <= 1'b0;
      else if (dlyRun_ff)
        dlyCnt_ff <= 8'(dlyCnt_ff + 8'h01);
    end
  end

  // ----------------------------------------------------------------
  // conversion sequencer
  // ----------------------------------------------------------------
  logic convDone;

  atcc_prescaler u_prescaler (
    .clk_sys(clk_sys),
    .rst(rst),
    .run(!idle),
    .code(ctrl1_ff[2:0]),
    .tick(convClockTick)
  );

  assign sampling = (state_ff == ATCC_SAMPLE);
  assign convDone = (state_ff == ATCC_CONVERT) && convClockTick && (clkCnt_ff == TOTAL_CLKS - 5'h01);

  // sampling for four converter clocks, then twelve for the conversion
  always_comb
  begin
    nxt_state = state_ff;
    unique case (state_ff)
      ATCC_IDLE: if (startConv) nxt_state = ATCC_SAMPLE;
      ATCC_SAMPLE: if (!convEnabled) nxt_state = ATCC_IDLE;
        else if (convClockTick && clkCnt_ff == SAMPLE_CLKS - 5'h01) nxt_state = ATCC_CONVERT;
      ATCC_CONVERT: if (!convEnabled || convDone) nxt_state = ATCC_IDLE;
      default: nxt_state = ATCC_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      state_ff <= ATCC_IDLE;
      clkCnt_ff <= 5'h00;
      busy_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      busy_ff <= (nxt_state != ATCC_IDLE);
      if (idle)
        clkCnt_ff <= 5'h00;
      else if (convClockTick)
        clkCnt_ff <= 5'(clkCnt_ff + 5'h01);
    end
  end

  // ----------------------------------------------------------------
  // result capture and bound compare
  // ----------------------------------------------------------------
  logic [11:0] lowBoundValue;
  logic [11:0] highBoundValue;
  logic cmpHit;
  logic cmpEvent;

  assign lowBoundValue = join12(lowH_ff, lowL_ff, alignRight);
  assign highBoundValue = join12(highH_ff, highL_ff, alignRight);
  always_comb
  begin
    unique case (trigCmp_ff[4:3])
      2'h0: cmpHit = (conversionResult > lowBoundValue) && (conversionResult < highBoundValue);
      2'h1: cmpHit = (conversionResult <= lowBoundValue);
      2'h2: cmpHit = (conversionResult >= highBoundValue);
      2'h3: cmpHit = (conversionResult <= lowBoundValue) || (conversionResult >= highBoundValue);
    endcase
  end
  assign cmpEvent = convDone && resultValid && (ctrl1_ff[7:5] == SRC_OPAMP) && cmpHit;

  // result held unless a conversion completes; status set wins over clear
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      result_ff <= 12'h000;
      status_ff <= 2'h0;
    end
    else
    begin
      if (convDone && resultValid)
        result_ff <= conversionResult;
      status_ff[ST_EOC] <= convDone ||
        (status_ff[ST_EOC] && !(wrEn && paddr == ADDR_STATUS && wByte[ST_EOC]));
      status_ff[ST_CMP] <= cmpEvent ||
        (status_ff[ST_CMP] && !(wrEn && paddr == ADDR_STATUS && wByte[ST_CMP]));
    end
  end

  assign convInterruptFlag = status_ff[ST_EOC];
  assign convInterrupt = status_ff[ST_EOC] && convIntEnable;
  assign compareInterrupt = status_ff[ST_CMP] && cmpIntEnable;

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  logic [7:0] rdByte;
  always_comb
  begin
    unique case (paddr)
      ADDR_CTRL0: rdByte = {ctrl0_ff[7], busy_ff, ctrl0_ff[5:0]};
      ADDR_CTRL1: rdByte = ctrl1_ff;
      ADDR_REFGAIN: rdByte = refGain_ff;
      ADDR_TRIGCMP: rdByte = trigCmp_ff;
      ADDR_DELAY: rdByte = delay_ff;
      ADDR_BANDGAP: rdByte = bandgap_ff;
      ADDR_LOWH: rdByte = lowH_ff;
      ADDR_LOWL: rdByte = lowL_ff;
      ADDR_HIGHH: rdByte = highH_ff;
      ADDR_HIGHL: rdByte = highL_ff;
      ADDR_RESH: rdByte = hiByte(result_ff, alignRight);
      ADDR_RESL: rdByte = loByte(result_ff, alignRight);
      ADDR_STATUS: rdByte = {6'h00, status_ff};
      default: rdByte = 8'h00;
    endcase
  end
  assign prdata = {24'h000000, rdByte};

endmodule : atcc_ctrl

/* atcc_ctrl_chk.sv */
// atcc_ctrl_chk: port assertions for the converter control
// assumes: bound into atcc_ctrl, one clock, sync reset high
module atcc_ctrl_chk
  import atcc_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  // routing
  input wire logic converterEnable,
  input wire logic sampling,
  input wire logic [2:0] inputSourceSelect,
  input wire logic externalChannelConnect,
  input wire logic gainAmpEnable,
  input wire logic bandgapToAmp,
  input wire logic bandgapEnable,
  input wire logic [1:0] referenceSelect,
  input wire logic externalRefPinConnect,
  input wire logic [1:0] gainSelect,
  // events
  input wire logic convInterruptFlag,
  input wire logic convInterrupt,
  input wire logic compareInterrupt,
  input wire logic convIntEnable,
  input wire logic cmpIntEnable
);
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic wrAcc;
  // a completed apb write
  assign wrAcc = psel && penable && pwrite;
  property p_src_ext;
    inputSourceSelect != SRC_EXT |-> !externalChannelConnect;
  endproperty
  a_src_ext: assert property (p_src_ext) else $error("ext channel on");
  property p_ref_pin;
    externalRefPinConnect == (referenceSelect == 2'h1);
  endproperty
  a_ref_pin: assert property (p_ref_pin) else $error("ref pin wrong");
  property p_refgain_wr;
    wrAcc && paddr == ADDR_REFGAIN |=> gainAmpEnable == $past(pwdata[7]) && bandgapToAmp == $past(pwdata[4])
      && referenceSelect == $past(pwdata[3:2]) && gainSelect == $past(pwdata[1:0]);
  endproperty
  a_refgain_wr: assert property (p_refgain_wr) else $error("refgain fields");
  property p_bg_wr;
    wrAcc && paddr == ADDR_BANDGAP |=> bandgapEnable == $past(pwdata[0]);
  endproperty
  a_bg_wr: assert property (p_bg_wr) else $error("bandgap enable");
  property p_irq;
    convInterrupt == (convInterruptFlag && convIntEnable);
  endproperty
  a_irq: assert property (p_irq) else $error("conv irq");
  property p_cmp_irq;
    compareInterrupt |-> cmpIntEnable;
  endproperty
  a_cmp_irq: assert property (p_cmp_irq) else $error("cmp irq masked");
  property p_flag_hold;
    convInterruptFlag && !(wrAcc && paddr == ADDR_STATUS && pwdata[ST_EOC]) |=> convInterruptFlag;
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("eoc flag lost");
  property p_start_en;
    $rose(sampling) |-> converterEnable;
  endproperty
  a_start_en: assert property (p_start_en) else $error("start while off");
endmodule : atcc_ctrl_chk

bind atcc_ctrl atcc_ctrl_chk u_atcc_ctrl_chk (
  .clk_sys, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .converterEnable, .sampling,
  .inputSourceSelect, .externalChannelConnect, .gainAmpEnable, .bandgapToAmp, .bandgapEnable,
  .referenceSelect, .externalRefPinConnect, .gainSelect, .convInterruptFlag, .convInterrupt,
  .compareInterrupt, .convIntEnable, .cmpIntEnable
);

/* atcc_pwm_model.sv */
// atcc_pwm_model: pwm match flags and analog core result
// assumes: same clock as the design; the bench calls the tasks
module atcc_pwm_model
(
  // clock and power
  input wire logic clk_sys,
  input wire logic converterEnable,
  // pwm flags and result
  output logic pwmPeriodFlag,
  output logic [2:0] pwmDutyFlag,
  output logic [11:0] conversionResult,
  output logic resultValid
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [11:0] res_ff = 12'h000;
  // result only stands while powered; otherwise an inverted pattern
  assign resultValid = converterEnable;
  assign conversionResult = converterEnable ? res_ff : ~res_ff;
  initial
  begin
    pwmPeriodFlag = 1'b0;
    pwmDutyFlag = 3'h0;
  end
  // value the core will deliver
  task automatic set_res(input logic [11:0] v);
    res_ff = v;
  endtask : set_res
  // match flag high for two clocks; sel 3 is the period flag
  task automatic pulse(input int sel);
    @(posedge clk_sys);
    if (sel == 3)
      pwmPeriodFlag <= 1'b1;
    else
      pwmDutyFlag[sel] <= 1'b1;
    repeat (2) @(posedge clk_sys);
    pwmPeriodFlag <= 1'b0;
    pwmDutyFlag <= 3'h0;
  endtask : pulse
endmodule : atcc_pwm_model

/* atcc_ctrl_bench.sv */
// atcc_ctrl_bench: self-checking bench for the converter control
// assumes: atcc_pwm_model stands for the pwm unit and the analog core
module atcc_ctrl_bench
  import atcc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------------------------------
  // signals, design and partner
  // ----------------------------------------------------------------
  logic clk_sys, rst, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic pwmPeriodFlag, resultValid, convIntEnable, cmpIntEnable, converterEnable, convClockTick, sampling;
  logic [2:0] pwmDutyFlag, inputSourceSelect;
  logic [11:0] conversionResult;
  logic externalChannelConnect, gainAmpEnable, ampRefInputPinConnect, bandgapToAmp, bandgapEnable;
  logic externalRefPinConnect, convInterruptFlag, convInterrupt, compareInterrupt;
  logic [3:0] externalChannelSelect;
  logic [1:0] referenceSelect, gainSelect;
  int n_fail = 0, compares = 0, cyc = 0, n;
  atcc_ctrl u_atcc_ctrl (.clk_sys, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .pwmPeriodFlag, .pwmDutyFlag, .conversionResult, .resultValid, .converterEnable,
    .convClockTick, .sampling, .inputSourceSelect, .externalChannelSelect, .externalChannelConnect,
    .gainAmpEnable, .ampRefInputPinConnect, .bandgapToAmp, .bandgapEnable, .referenceSelect,
    .externalRefPinConnect, .gainSelect, .convInterruptFlag, .convInterrupt, .compareInterrupt,
    .convIntEnable, .cmpIntEnable);
  atcc_pwm_model u_atcc_pwm_model (.clk_sys, .converterEnable, .pwmPeriodFlag, .pwmDutyFlag,
    .conversionResult, .resultValid);
  // clock
  initial
  begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  // cycle ceiling cuts a hang short
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      n_fail++;
      close_out();
    end
  end
  task automatic close_out();
    $display("compares %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : close_out
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // one apb transfer; one idle clock follows the access edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 8'h00);
  endtask : rd
  // waits for end of conversion, clocks taken in n
  task automatic wait_eoc();
    n = 0;
    while (convInterruptFlag !== 1'b1 && n < 5000)
    begin
      @(posedge clk_sys);
      n++;
    end
  endtask : wait_eoc
  task automatic conv(input logic [7:0] b);
    wr(ADDR_CTRL0, b | 8'h80);
    wr(ADDR_CTRL0, b);
    wait_eoc();
  endtask : conv
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    logic [7:0] ad [5] = '{ADDR_CTRL1, ADDR_REFGAIN, ADDR_TRIGCMP, ADDR_DELAY, ADDR_BANDGAP};
    logic [7:0] mk [5] = '{MASK_CTRL1, MASK_REFGAIN, MASK_TRIGCMP, 8'hff, MASK_BANDGAP};
    for (int a = 0; a <= 8'h30; a += 4)
    begin
      rd(8'(a));
      chk("reset value", q, 0);
    end
    chk("amp pin reset", ampRefInputPinConnect, 1);
    for (int i = 0; i < 5; i++)
    begin
      wr(ad[i], 8'hff);
      rd(ad[i]);
      chk("write mask", q, mk[i]);
      wr(ad[i], 8'h00);
    end
    rd(8'h34);
    chk("unmapped error", err, 1);
    chk("unmapped data", q, 0);
    wr(ADDR_RESH, 8'hff);
    rd(ADDR_RESH);
    chk("read only", q, 0);
  endtask : t_regs
  task automatic t_route();
    logic [1:0] s;
    wr(ADDR_CTRL0, 8'h2b);
    chk("channel", externalChannelSelect, 4'hb);
    for (int i = 0; i < 8; i++)
    begin
      wr(ADDR_CTRL1, 8'(i << 5));
      chk("source", inputSourceSelect, i);
      chk("ext connect", externalChannelConnect, i == 0);
    end
    for (int i = 0; i < 4; i++)
    begin
      s = 2'(i);
      wr(ADDR_BANDGAP, {7'h0, |s});
      chk("bandgap", bandgapEnable, |s);
      wr(ADDR_REFGAIN, {1'b1, 2'b00, s[0], s, s});
      chk("amp on", gainAmpEnable, 1);
      chk("ref select", referenceSelect, s);
      chk("gain", gainSelect, s);
      chk("ref pin", externalRefPinConnect, s == 2'h1);
      chk("amp pin", ampRefInputPinConnect, !s[0]);
    end
    wr(ADDR_REFGAIN, 8'h00);
    chk("amp off", gainAmpEnable, 0);
  endtask : t_route
  task automatic t_soft();
    logic [7:0] b;
    convIntEnable <= 1'b1;
    u_atcc_pwm_model.set_res(12'habc);
    for (int c = 0; c < 2; c++)
    begin
      b = c ? 8'h20 : 8'h30;
      wr(ADDR_CTRL1, 8'(c * 7));
      wr(ADDR_CTRL0, b | 8'h80);
      wr(ADDR_CTRL0, b);
      rd(ADDR_CTRL0);
      chk("busy set", q[CTRL0_BUSY], 1);
      wr(ADDR_CTRL0, b | 8'h80);
      wr(ADDR_CTRL0, b);
      wait_eoc();
      n = n + 10;
      chk("conv time", n >= (16 << (c * 7)) - 1 && n <= (17 << (c * 7)) + 2, 1);
      chk("irq", convInterrupt, 1);
      rd(ADDR_CTRL0);
      chk("busy clear", q[CTRL0_BUSY], 0);
      rd(ADDR_RESH);
      chk("result high", q, c ? 32'hab : 32'h0a);
      rd(ADDR_RESL);
      chk("result low", q, c ? 32'hc0 : 32'hbc);
      wr(ADDR_STATUS, 8'h02);
      repeat (60) @(posedge clk_sys);
      chk("no queued conv", convInterruptFlag, 0);
    end
    convIntEnable <= 1'b0;
  endtask : t_soft
  task automatic t_pwm();
    int ok [5] = '{3, 0, 1, 2, 2};
    int bad [5] = '{0, 3, 3, 3, 0};
    wr(ADDR_CTRL1, 8'h00);
    for (int k = 0; k < 5; k++)
    begin
      wr(ADDR_TRIGCMP, k ? 8'(8'ha0 + k - 1) : 8'h80);
      u_atcc_pwm_model.pulse(bad[k]);
      repeat (30) @(posedge clk_sys);
      chk("wrong source", convInterruptFlag, 0);
      u_atcc_pwm_model.pulse(ok[k]);
      wait_eoc();
      chk("pwm start", convInterruptFlag, 1);
      wr(ADDR_STATUS, 8'h02);
    end
    wr(ADDR_DELAY, 8'h20);
    wr(ADDR_TRIGCMP, 8'hc0);
    u_atcc_pwm_model.pulse(3);
    n = 0;
    while (sampling !== 1'b1 && n < 100)
    begin
      @(posedge clk_sys);
      n++;
    end
    chk("start delay", n >= 29 && n <= 35, 1);
    wait_eoc();
    wr(ADDR_STATUS, 8'h02);
    wr(ADDR_TRIGCMP, 8'h00);
    wr(ADDR_DELAY, 8'h00);
  endtask : t_pwm
  task automatic t_cmp();
    logic [11:0] rv [3] = '{12'h100, 12'h400, 12'h800};
    logic e;
    cmpIntEnable <= 1'b1;
    wr(ADDR_CTRL1, 8'h20);
    wr(ADDR_LOWH, 8'h01);
    wr(ADDR_LOWL, 8'h00);
    wr(ADDR_HIGHH, 8'h08);
    wr(ADDR_HIGHL, 8'h00);
    for (int c = 0; c < 4; c++)
      for (int j = 0; j < 3; j++)
      begin
        case (c)
          0: e = rv[j] > 12'h100 && rv[j] < 12'h800;
          1: e = rv[j] <= 12'h100;
          2: e = rv[j] >= 12'h800;
          default: e = rv[j] <= 12'h100 || rv[j] >= 12'h800;
        endcase
        wr(ADDR_TRIGCMP, 8'(c << 3));
        u_atcc_pwm_model.set_res(rv[j]);
        conv(8'h30);
        rd(ADDR_STATUS);
        chk("compare flag", q, {30'h0, 1'b1, e});
        chk("compare irq", compareInterrupt, e);
        wr(ADDR_STATUS, 8'h03);
      end
    wr(ADDR_CTRL1, 8'h00);
    wr(ADDR_TRIGCMP, 8'h08);
    u_atcc_pwm_model.set_res(12'h000);
    conv(8'h30);
    chk("other source", compareInterrupt, 0);
    wr(ADDR_CTRL0, 8'h10);
    wr(ADDR_LOWH, 8'h0f);
    rd(ADDR_LOWH);
    chk("bound kept", q, 32'h01);
    cmpIntEnable <= 1'b0;
  endtask : t_cmp
  // main sequence
  initial
  begin
    rst = 1'b1;
    {psel, penable, pwrite, paddr, pwdata, convIntEnable, cmpIntEnable} = '0;
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    t_regs();
    t_route();
    t_soft();
    t_pwm();
    t_cmp();
    close_out();
  end
endmodule : atcc_ctrl_bench
